/* File: src/pmc_defs.svh */
/*
  Constants for the power mode controller: register indices, field
  positions, reset values and timing counts.
  Assumes a 10 MHz system clock and an APB slave with 32-bit data.
*/
// Notes on behaviour
// - Idle select halts the CPU after the setting instruction; state is kept.
// - In idle, peripheral, timer, interrupt and serial clocks keep running.
// - An enabled interrupt ends idle, clears idle select and restarts the CPU.
// - After that interrupt returns, execution continues after the idle-setting instruction.
// - A reset during idle runs the reset sequence and starts at 0x0000.
// - An enabled watchdog keeps counting in idle; expiry resets the device.
// - Stop select halts oscillator, CPU and digital peripherals; external oscillator untouched.
// - In stop only the missing clock detector runs; analog enables unchanged.
// - Only a reset ends stop; then reset sequence and start at 0x0000.
// - Enabled missing clock detector resets after about 100 us in stop.
// - Suspend bit halts CPU and internal oscillator after the instruction; state kept.
// - In suspend digital peripherals stop but port match keeps working.
// - Suspend ends only on port match, enabled comparator low, or reset.
// - A non-reset wake from suspend resumes after the suspend-setting instruction.
// - A wake source set to interrupt is serviced right after waking.
// - A reset during suspend runs the reset sequence and starts at 0x0000.
// - Power control at index 0x87: bit1 stop, bit0 idle, bits 7:2 flags.
// - Stop and idle select bits always read as 0.
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

// Register indices; byte address is four times the index
`define PMC_IDX_PWR_CTRL    12'h087
`define PMC_IDX_OSC_CTRL    12'h088
`define PMC_IDX_REF_CTRL    12'h089
`define PMC_IDX_CFG         12'h08a
`define PMC_IDX_WDT         12'h08b
`define PMC_IDX_STATUS      12'h08c

// Field positions
`define PMC_BIT_IDLE        0
`define PMC_BIT_STOP        1
`define PMC_BIT_SUSPEND     5
`define PMC_BIT_ZTC         3
`define PMC_BIT_WDT_EN      0
`define PMC_BIT_MCD_EN      1
`define PMC_BIT_CMP_WAKE    2
`define PMC_BIT_PM_IRQ      3
`define PMC_BIT_CMP_IRQ     4

// Reset values
`define PMC_RST_FLAGS       6'h00
`define PMC_RST_CFG         5'h00
`define PMC_RESET_VECTOR    16'h0000

// Timing
`define PMC_CLK_PERIOD_NS   100
`define PMC_MCD_TIMEOUT_NS  100000
`define PMC_MCD_CYCLES      (`PMC_MCD_TIMEOUT_NS / `PMC_CLK_PERIOD_NS)
`define PMC_WDT_DIV         12
`define PMC_WDT_TICKS       65535
`define PMC_RST_HOLD        4

`endif

/* File: src/pmc_pkg.sv */
/*
  Types shared by the power mode controller files.
  Assumes the constants header is included by each user.
*/
package pmc_pkg;

  typedef enum logic [2:0]
  {
    PMC_RESET    = 3'b000,
    PMC_RUN      = 3'b001,
    PMC_ARM_IDLE = 3'b010,
    PMC_ARM_STOP = 3'b011,
    PMC_ARM_SUSP = 3'b100,
    PMC_IDLE     = 3'b101,
    PMC_STOP     = 3'b110,
    PMC_SUSP     = 3'b111
  } pmc_mode_type;

  typedef enum logic [1:0]
  {
    PMC_CAUSE_POR = 2'b00,
    PMC_CAUSE_PIN = 2'b01,
    PMC_CAUSE_WDT = 2'b10,
    PMC_CAUSE_MCD = 2'b11
  } pmc_cause_type;

endpackage

/* File: src/pmc_mcd_timer.sv */
/*
  Missing clock detector timeout for the power mode controller.
  Counts while the system clock is held in stop; assumes clear_i is a
  same-domain level from the parent.
*/
`timescale 1ns/1ps
`include "pmc_defs.svh"

module pmc_mcd_timer
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic nrst_i,
  // Control
  input  wire logic clear_i,
  input  wire logic run_i,
  // Expiry
  output logic      expire_o
);

  localparam logic [9:0] MCD_LAST = 10'((`PMC_MCD_CYCLES) - 1);

  logic [9:0] cnt_ff;
  logic       expire_ff;

  // Timeout counter; restarts whenever the detector is idle
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i || clear_i || !run_i)
      cnt_ff <= 10'h000;
    else if (cnt_ff != MCD_LAST)
      cnt_ff <= cnt_ff + 10'h001;
  end

  // One pulse when the timeout is reached
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i || clear_i)
      expire_ff <= 1'b0;
    else
      expire_ff <= run_i && (cnt_ff == MCD_LAST - 10'h001);
  end

  assign expire_o = expire_ff;

endmodule

/* File: src/pmc_power_mode_ctrl.sv */
/*
  Power mode controller: idle, stop and suspend entry at an instruction
  boundary, wake handling, watchdog, and reset sequencing to the reset
  vector, with its registers on APB.
  Assumes the CPU pulses insn_done_i as each instruction completes and
  that irq_pending_i comes from an interrupt controller on clk_i.
*/
`timescale 1ns/1ps
`include "pmc_defs.svh"

module pmc_power_mode_ctrl
#(
  parameter int WDT_TICKS = `PMC_WDT_TICKS
)
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // APB slave
  input  wire logic [11:0] paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // CPU side
  input  wire logic        insn_done_i,
  input  wire logic        irq_pending_i,
  output logic             cpu_clk_en_o,
  output logic             cpu_rst_o,
  output logic [15:0]      reset_vector_o,
  output logic             resume_o,
  output logic             wake_irq_o,
  // Pins
  input  wire logic        ext_rst_n_i,
  input  wire logic        port_match_i,
  input  wire logic        cmp_low_i,
  // Clock and enable controls
  output logic             periph_clk_en_o,
  output logic             int_osc_en_o,
  output logic             port_match_en_o,
  output logic             ztc_en_o
);

  localparam logic [15:0] WDT_LAST = 16'(WDT_TICKS - 1);
  localparam logic [3:0]  DIV_LAST = 4'(`PMC_WDT_DIV - 1);
  localparam logic [2:0]  HOLD_LAST = 3'(`PMC_RST_HOLD - 1);

  // Byte address of a register index
  function automatic logic [11:0] reg_addr(input logic [11:0] idx);
    reg_addr = {idx[9:0], 2'b00};
  endfunction

  pmc_pkg::pmc_mode_type  state_ff;
  pmc_pkg::pmc_mode_type  nxt_state;
  pmc_pkg::pmc_cause_type cause_ff;
  logic [5:0]  flags_ff;
  logic        ztc_ff;
  logic [4:0]  cfg_ff;
  logic [15:0] wdt_cnt_ff;
  logic [3:0]  div_ff;
  logic [2:0]  hold_ff;
  logic [31:0] prdata_ff;
  logic        resume_ff;
  logic        wake_irq_ff;
  logic [1:0]  ext_rst_sync_ff;
  logic [1:0]  pm_sync_ff;
  logic [1:0]  cmp_sync_ff;
  logic        wdt_exp;
  logic        mcd_exp;
  logic        ext_rst;
  logic        rst_evt;
  logic        clear;
  logic        wr_en;
  logic        setup;
  logic        mapped;
  logic        wdt_run;
  logic        pm_wake;
  logic        cmp_wake;
  logic [31:0] rd_val;

  // Pin synchronisers; only the second stage is read
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      ext_rst_sync_ff <= 2'h3;
      pm_sync_ff      <= 2'h0;
      cmp_sync_ff     <= 2'h0;
    end
    else
    begin
      ext_rst_sync_ff <= {ext_rst_sync_ff[0], ext_rst_n_i};
      pm_sync_ff      <= {pm_sync_ff[0], port_match_i};
      cmp_sync_ff     <= {cmp_sync_ff[0], cmp_low_i};
    end
  end

  // Any device reset source; each restarts from the reset vector
  assign ext_rst = !ext_rst_sync_ff[1];
  assign rst_evt = ext_rst || wdt_exp || mcd_exp;
  assign clear   = !nrst_i || rst_evt;

  // APB decode; zero wait states, unmapped addresses answer with an error
  assign setup  = psel_i && !penable_i;
  assign wr_en  = psel_i && penable_i && pwrite_i && pstrb_i[0];
  assign mapped = (paddr_i == reg_addr(`PMC_IDX_PWR_CTRL)) || (paddr_i == reg_addr(`PMC_IDX_OSC_CTRL)) ||
                  (paddr_i == reg_addr(`PMC_IDX_REF_CTRL)) || (paddr_i == reg_addr(`PMC_IDX_CFG)) ||
                  (paddr_i == reg_addr(`PMC_IDX_WDT))      || (paddr_i == reg_addr(`PMC_IDX_STATUS));
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;

  // Read mux; idle and stop select bits are write-triggered so they never read back
  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (paddr_i == reg_addr(`PMC_IDX_PWR_CTRL))
      rd_val = {24'h00_0000, flags_ff, 2'b00};
    else if (paddr_i == reg_addr(`PMC_IDX_OSC_CTRL))
      rd_val = {26'h000_0000, (state_ff == pmc_pkg::PMC_ARM_SUSP), 5'h00};
    else if (paddr_i == reg_addr(`PMC_IDX_REF_CTRL))
      rd_val = {28'h000_0000, ztc_ff, 3'h0};
    else if (paddr_i == reg_addr(`PMC_IDX_CFG))
      rd_val = {27'h000_0000, cfg_ff};
    else if (paddr_i == reg_addr(`PMC_IDX_WDT))
      rd_val = {16'h0000, wdt_cnt_ff};
    else if (paddr_i == reg_addr(`PMC_IDX_STATUS))
      rd_val = {26'h000_0000, cause_ff, 1'b0, state_ff};
  end

  // Read data captured in the setup cycle so it comes from a flop
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      prdata_ff <= 32'h0000_0000;
    else if (setup && !pwrite_i)
      prdata_ff <= rd_val;
  end

  assign prdata_o = prdata_ff;

  // General purpose flags
  always_ff @(posedge clk_i)
  begin
    if (clear)
      flags_ff <= `PMC_RST_FLAGS;
    else if (wr_en && paddr_i == reg_addr(`PMC_IDX_PWR_CTRL))
      flags_ff <= pwdata_i[7:2];
  end

  // Voltage reference tempco enable; firmware must set it before suspend
  always_ff @(posedge clk_i)
  begin
    if (clear)
      ztc_ff <= 1'b0;
    else if (wr_en && paddr_i == reg_addr(`PMC_IDX_REF_CTRL))
      ztc_ff <= pwdata_i[`PMC_BIT_ZTC];
  end

  // Wake and reset source configuration
  always_ff @(posedge clk_i)
  begin
    if (clear)
      cfg_ff <= `PMC_RST_CFG;
    else if (wr_en && paddr_i == reg_addr(`PMC_IDX_CFG))
      cfg_ff <= pwdata_i[4:0];
  end

  // Watchdog runs in run and idle, never in stop or suspend
  assign wdt_run = cfg_ff[`PMC_BIT_WDT_EN] &&
                   (state_ff != pmc_pkg::PMC_STOP) && (state_ff != pmc_pkg::PMC_SUSP) &&
                   (state_ff != pmc_pkg::PMC_RESET);

  // Divide-by-12 tick for the watchdog
  always_ff @(posedge clk_i)
  begin
    if (clear || !wdt_run)
      div_ff <= 4'h0;
    else if (div_ff == DIV_LAST)
      div_ff <= 4'h0;
    else
      div_ff <= div_ff + 4'h1;
  end

  // Watchdog count; any write to its register with pstrb_i[0] set reloads it
  always_ff @(posedge clk_i)
  begin
    if (clear)
      wdt_cnt_ff <= 16'h0000;
    else if (wr_en && paddr_i == reg_addr(`PMC_IDX_WDT))
      wdt_cnt_ff <= 16'h0000;
    else if (wdt_run && div_ff == DIV_LAST && wdt_cnt_ff != WDT_LAST)
      wdt_cnt_ff <= wdt_cnt_ff + 16'h0001;
  end

  assign wdt_exp = wdt_run && (div_ff == DIV_LAST) && (wdt_cnt_ff == WDT_LAST);

  // Missing clock detector watches the stopped system clock
  pmc_mcd_timer u_mcd
  (
    .clk_i    (clk_i),
    .nrst_i   (nrst_i),
    .clear_i  (rst_evt),
    .run_i    (cfg_ff[`PMC_BIT_MCD_EN] && state_ff == pmc_pkg::PMC_STOP),
    .expire_o (mcd_exp)
  );

  // Suspend wake sources
  assign pm_wake  = pm_sync_ff[1];
  assign cmp_wake = cfg_ff[`PMC_BIT_CMP_WAKE] && cmp_sync_ff[1];

  // Mode sequencing
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      pmc_pkg::PMC_RESET:
        if (hold_ff == HOLD_LAST)
          nxt_state = pmc_pkg::PMC_RUN;
      pmc_pkg::PMC_RUN:
        // Stop wins if both select bits are written together
        if (wr_en && paddr_i == reg_addr(`PMC_IDX_PWR_CTRL) && pwdata_i[`PMC_BIT_STOP])
          nxt_state = pmc_pkg::PMC_ARM_STOP;
        else if (wr_en && paddr_i == reg_addr(`PMC_IDX_PWR_CTRL) && pwdata_i[`PMC_BIT_IDLE])
          nxt_state = pmc_pkg::PMC_ARM_IDLE;
        else if (wr_en && paddr_i == reg_addr(`PMC_IDX_OSC_CTRL) && pwdata_i[`PMC_BIT_SUSPEND])
          nxt_state = pmc_pkg::PMC_ARM_SUSP;
      pmc_pkg::PMC_ARM_IDLE:
        if (insn_done_i)
          nxt_state = pmc_pkg::PMC_IDLE;
      pmc_pkg::PMC_ARM_STOP:
        if (insn_done_i)
          nxt_state = pmc_pkg::PMC_STOP;
      pmc_pkg::PMC_ARM_SUSP:
        if (insn_done_i)
          nxt_state = pmc_pkg::PMC_SUSP;
      pmc_pkg::PMC_IDLE:
        if (irq_pending_i)
          nxt_state = pmc_pkg::PMC_RUN;
      pmc_pkg::PMC_STOP:
        nxt_state = pmc_pkg::PMC_STOP;
      pmc_pkg::PMC_SUSP:
        if (pm_wake || cmp_wake)
          nxt_state = pmc_pkg::PMC_RUN;
      default:
        nxt_state = pmc_pkg::PMC_RESET;
    endcase
  end

  // Any reset, from any mode, restarts the reset sequence
  always_ff @(posedge clk_i)
  begin
    if (clear)
      state_ff <= pmc_pkg::PMC_RESET;
    else
      state_ff <= nxt_state;
  end

  // Reset hold counter; an external reset held low keeps it at zero
  always_ff @(posedge clk_i)
  begin
    if (clear || state_ff != pmc_pkg::PMC_RESET)
      hold_ff <= 3'h0;
    else if (hold_ff != HOLD_LAST)
      hold_ff <= hold_ff + 3'h1;
  end

  // Cause of the last reset; survives the internal resets it records
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      cause_ff <= pmc_pkg::PMC_CAUSE_POR;
    else if (ext_rst)
      cause_ff <= pmc_pkg::PMC_CAUSE_PIN;
    else if (wdt_exp)
      cause_ff <= pmc_pkg::PMC_CAUSE_WDT;
    else if (mcd_exp)
      cause_ff <= pmc_pkg::PMC_CAUSE_MCD;
  end

  // Resume and wake interrupt pulses; the CPU keeps its program counter
  always_ff @(posedge clk_i)
  begin
    if (clear)
    begin
      resume_ff   <= 1'b0;
      wake_irq_ff <= 1'b0;
    end
    else
    begin
      resume_ff   <= (state_ff == pmc_pkg::PMC_IDLE && irq_pending_i) ||
                     (state_ff == pmc_pkg::PMC_SUSP && (pm_wake || cmp_wake));
      wake_irq_ff <= state_ff == pmc_pkg::PMC_SUSP &&
                     ((pm_wake && cfg_ff[`PMC_BIT_PM_IRQ]) ||
                      (cmp_wake && cfg_ff[`PMC_BIT_CMP_IRQ]));
    end
  end

  // Clock gates decoded from the mode; registers and memory are never cleared here
  assign cpu_clk_en_o    = (state_ff == pmc_pkg::PMC_RUN) || (state_ff == pmc_pkg::PMC_ARM_IDLE) ||
                           (state_ff == pmc_pkg::PMC_ARM_STOP) || (state_ff == pmc_pkg::PMC_ARM_SUSP);
  assign periph_clk_en_o = cpu_clk_en_o || (state_ff == pmc_pkg::PMC_IDLE);
  assign int_osc_en_o    = (state_ff != pmc_pkg::PMC_STOP) && (state_ff != pmc_pkg::PMC_SUSP);
  assign port_match_en_o = state_ff != pmc_pkg::PMC_STOP;
  assign cpu_rst_o       = state_ff == pmc_pkg::PMC_RESET;
  assign reset_vector_o  = `PMC_RESET_VECTOR;
  assign resume_o        = resume_ff;
  assign wake_irq_o      = wake_irq_ff;
  assign ztc_en_o        = ztc_ff;

endmodule

/* File: tb/pmc_cpu_model.sv */
/*
  CPU core stand-in: retires an instruction every gap_i+1 cycles.
  Assumes clock enable and reset come from the controller on clk_i.
*/
`timescale 1ns/1ps

module pmc_cpu_model
(
  // Clock
  input  wire logic       clk_i,
  // Controller side
  input  wire logic       cpu_clk_en_i,
  input  wire logic       cpu_rst_i,
  input  wire logic [1:0] gap_i,
  output logic            insn_done_o = 1'b0
);
  logic [1:0] cnt_ff = 2'h0;

  // A halted or reset core retires nothing; the gap keeps the
  // instruction after a select write a multi-byte one
  always_ff @(posedge clk_i)
  begin
    if (cpu_rst_i || !cpu_clk_en_i)
    begin
      cnt_ff      <= 2'h0;
      insn_done_o <= 1'b0;
    end
    else
    begin
      cnt_ff      <= (cnt_ff >= gap_i) ? 2'h0 : cnt_ff + 2'h1;
      insn_done_o <= (cnt_ff >= gap_i);
    end
  end
endmodule

/* File: tb/pmc_power_mode_ctrl_monitor.sv */
/*
  Port checker for the power mode controller.
  Assumes one clock domain; bound to the controller module by the bind below.
*/
`timescale 1ns/1ps

module pmc_power_mode_ctrl_monitor
(
  // Clock, reset, APB
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic [11:0] paddr_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [31:0] prdata_o,
  // CPU side and pins
  input wire logic        irq_pending_i,
  input wire logic        ext_rst_n_i,
  input wire logic        port_match_i,
  input wire logic        cpu_clk_en_o,
  input wire logic        cpu_rst_o,
  input wire logic [15:0] reset_vector_o,
  input wire logic        resume_o,
  input wire logic        wake_irq_o,
  input wire logic        periph_clk_en_o,
  input wire logic        int_osc_en_o,
  input wire logic        port_match_en_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  // Modes decoded from the enables, since the state is not a port
  wire idle_w = !cpu_rst_o && !cpu_clk_en_o && int_osc_en_o;
  wire stop_w = !cpu_rst_o && !int_osc_en_o && !port_match_en_o;
  wire susp_w = !cpu_rst_o && !int_osc_en_o && port_match_en_o;

  a_vector_zero: assert property (reset_vector_o == 16'h0000)
    else $error("reset vector not zero");
  a_reset_seq: assert property ($rose(nrst_i) |-> cpu_rst_o[*4] ##[1:2] !cpu_rst_o)
    else $error("reset hold wrong");
  a_idle_periph: assert property (idle_w |-> periph_clk_en_o)
    else $error("peripheral clock off in idle");
  a_idle_wake: assert property (idle_w && irq_pending_i && $past(ext_rst_n_i) && $past(ext_rst_n_i, 2) |=> cpu_clk_en_o)
    else $error("interrupt did not end idle");
  a_stop_quiet: assert property (stop_w |-> !periph_clk_en_o && !cpu_clk_en_o)
    else $error("clocks running in stop");
  a_stop_held: assert property (stop_w |=> stop_w || cpu_rst_o)
    else $error("stop left without reset");
  a_susp_wake: assert property (susp_w && port_match_i && ext_rst_n_i |-> ##[1:4] cpu_clk_en_o)
    else $error("port match did not wake");
  a_resume_run: assert property (resume_o |-> cpu_clk_en_o && !cpu_rst_o)
    else $error("resume without running cpu");
  a_wake_irq_pair: assert property (wake_irq_o |-> resume_o)
    else $error("wake interrupt without resume");
  a_select_reads0: assert property (psel_i && penable_i && !pwrite_i && paddr_i == 12'h21c |-> prdata_o[1:0] == 2'b00)
    else $error("select bits read nonzero");
  a_pin_reset: assert property (!ext_rst_n_i [*3] |=> cpu_rst_o)
    else $error("pin reset not taken");
endmodule

bind pmc_power_mode_ctrl pmc_power_mode_ctrl_monitor mon_u
(
  .clk_i(clk_i), .nrst_i(nrst_i), .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .prdata_o(prdata_o), .irq_pending_i(irq_pending_i), .ext_rst_n_i(ext_rst_n_i),
  .port_match_i(port_match_i), .cpu_clk_en_o(cpu_clk_en_o), .cpu_rst_o(cpu_rst_o),
  .reset_vector_o(reset_vector_o), .resume_o(resume_o), .wake_irq_o(wake_irq_o),
  .periph_clk_en_o(periph_clk_en_o), .int_osc_en_o(int_osc_en_o), .port_match_en_o(port_match_en_o)
);

/* File: tb/pmc_power_mode_ctrl_tb_top.sv */
/*
  Self-checking bench for the power mode controller: APB master and pins.
  Assumes the CPU stand-in model and the bound port checker.
*/
`timescale 1ns/1ps
`include "pmc_defs.svh"

module pmc_power_mode_ctrl_tb_top;
  localparam logic [11:0] A_PWR = 12'(4 * `PMC_IDX_PWR_CTRL);
  localparam logic [11:0] A_OSC = 12'(4 * `PMC_IDX_OSC_CTRL);
  localparam logic [11:0] A_REF = 12'(4 * `PMC_IDX_REF_CTRL);
  localparam logic [11:0] A_CFG = 12'(4 * `PMC_IDX_CFG);
  localparam logic [11:0] A_STA = 12'(4 * `PMC_IDX_STATUS);
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [31:0] pwdata_i = 32'h0;
  logic [3:0]  pstrb_i = 4'hf;
  logic        irq_pending_i = 1'b0;
  logic        ext_rst_n_i = 1'b1;
  logic        port_match_i = 1'b0;
  logic        cmp_low_i = 1'b0;
  logic [1:0]  gap_i = 2'h1;
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o, insn_done_i, cpu_clk_en_o, cpu_rst_o, resume_o, wake_irq_o;
  logic        periph_clk_en_o, int_osc_en_o, port_match_en_o, ztc_en_o;
  logic [15:0] reset_vector_o;
  logic [31:0] rd_q, r;
  logic        rd_err;
  int          miscompares = 0, samples_checked = 0, waited, n_res = 0, n_wirq = 0, k, kr;
  wire  [1:0]  watch = {cpu_rst_o, cpu_clk_en_o};

  // Short count so watchdog expiry fits in the run
  pmc_power_mode_ctrl #(.WDT_TICKS(4)) dut_u
  (
    .clk_i(clk_i), .nrst_i(nrst_i), .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .insn_done_i(insn_done_i), .irq_pending_i(irq_pending_i),
    .cpu_clk_en_o(cpu_clk_en_o), .cpu_rst_o(cpu_rst_o), .reset_vector_o(reset_vector_o),
    .resume_o(resume_o), .wake_irq_o(wake_irq_o), .ext_rst_n_i(ext_rst_n_i), .port_match_i(port_match_i),
    .cmp_low_i(cmp_low_i), .periph_clk_en_o(periph_clk_en_o), .int_osc_en_o(int_osc_en_o),
    .port_match_en_o(port_match_en_o), .ztc_en_o(ztc_en_o)
  );
  pmc_cpu_model cpu_u
  (
    .clk_i(clk_i), .cpu_clk_en_i(cpu_clk_en_o), .cpu_rst_i(cpu_rst_o), .gap_i(gap_i), .insn_done_o(insn_done_i)
  );

  // 100 ns clock
  always #50 clk_i = ~clk_i;

  // Pulse counters, so one-cycle outputs are never missed
  always @(posedge clk_i)
  begin
    n_res  <= n_res + 32'(resume_o === 1'b1);
    n_wirq <= n_wirq + 32'(wake_irq_o === 1'b1);
  end

  function automatic logic [31:0] stat(input logic [2:0] st, input logic [1:0] cs);
    return {26'h0, cs, 1'b0, st};
  endfunction

  task automatic test_done();
    $display("samples_checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; held until pready is sampled, then released
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, 1'b0, wr, a, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    check("pready", 32'(pready_o), 32'h1);
    if (pready_o !== 1'b1)
      test_done();
    rd_q = prdata_o;
    rd_err = pslverr_o;
    {psel_i, penable_i} <= 2'b00;
  endtask

  // Bounded wait on a settled output; a timeout ends the run
  task automatic waitv(input int s, input logic v, input int lim);
    waited = 0;
    do
    begin
      @(negedge clk_i);
      waited++;
    end while (watch[s] !== v && waited < lim);
    if (watch[s] !== v)
    begin
      check("wait", 32'(watch[s]), 32'(v));
      test_done();
    end
  endtask

  task automatic pin_reset();
    @(posedge clk_i);
    ext_rst_n_i <= 1'b0;
    waitv(1, 1'b1, 10);
    @(posedge clk_i);
    ext_rst_n_i <= 1'b1;
    waitv(1, 1'b0, 20);
  endtask

  // Main sequence
  initial
  begin
    void'($urandom(32'h323f8b53));
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    waitv(1, 1'b0, 20);
    apb(1'b0, A_STA, 0); check("por", rd_q, stat(pmc_pkg::PMC_RUN, pmc_pkg::PMC_CAUSE_POR));
    apb(1'b0, A_PWR, 0); check("pwr rst", rd_q, 32'h0);
    repeat (4)
    begin
      r = $urandom & 32'hfc;
      apb(1'b1, A_PWR, r);
      pstrb_i <= 4'he;
      apb(1'b1, A_PWR, ~r & 32'hfc);
      pstrb_i <= 4'hf;
      apb(1'b0, A_PWR, 0); check("flags", rd_q, r);
    end
    apb(1'b0, 12'h3fc, 0); check("unmapped", {rd_q[30:0], rd_err}, 32'h1);
    // Idle, ended by an interrupt
    gap_i <= 2'($urandom_range(3));
    apb(1'b1, A_PWR, r | 32'h1);
    waitv(0, 1'b0, 40);
    apb(1'b0, A_STA, 0); check("idle", rd_q, stat(pmc_pkg::PMC_IDLE, pmc_pkg::PMC_CAUSE_POR));
    check("idle clk", {30'h0, periph_clk_en_o, int_osc_en_o}, 32'h3);
    apb(1'b0, A_PWR, 0); check("idle kept", rd_q, r);
    k = n_res;
    @(posedge clk_i);
    irq_pending_i <= 1'b1;
    waitv(0, 1'b1, 20);
    @(posedge clk_i);
    irq_pending_i <= 1'b0;
    repeat (2) @(negedge clk_i);
    check("resume", n_res - k, 32'h1);
    // Watchdog keeps counting in idle
    apb(1'b1, A_CFG, 32'h1);
    apb(1'b1, A_PWR, 32'h1);
    waitv(0, 1'b0, 40);
    waitv(1, 1'b1, 300);
    check("wdt time", 32'(waited < 60), 32'h1);
    waitv(1, 1'b0, 20);
    apb(1'b0, A_STA, 0); check("wdt", rd_q, stat(pmc_pkg::PMC_RUN, pmc_pkg::PMC_CAUSE_WDT));
    // Stop wins over idle; only a reset ends it
    apb(1'b1, A_PWR, r | 32'h3);
    waitv(0, 1'b0, 40);
    check("stop clk", {29'h0, periph_clk_en_o, int_osc_en_o, port_match_en_o}, 32'h0);
    apb(1'b0, A_PWR, 0); check("stop read", rd_q, r);
    irq_pending_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    irq_pending_i <= 1'b0;
    apb(1'b0, A_STA, 0); check("stop held", rd_q, stat(pmc_pkg::PMC_STOP, pmc_pkg::PMC_CAUSE_WDT));
    pin_reset();
    apb(1'b0, A_STA, 0); check("pin", rd_q, stat(pmc_pkg::PMC_RUN, pmc_pkg::PMC_CAUSE_PIN));
    check("vector", 32'(reset_vector_o), 32'h0);
    // Missing clock detector ends stop after 1000 cycles
    apb(1'b1, A_CFG, 32'h2);
    apb(1'b1, A_PWR, 32'h2);
    waitv(0, 1'b0, 40);
    waitv(1, 1'b1, 1100);
    check("mcd time", 32'(waited > 950), 32'h1);
    waitv(1, 1'b0, 20);
    apb(1'b0, A_STA, 0); check("mcd", rd_q, stat(pmc_pkg::PMC_RUN, pmc_pkg::PMC_CAUSE_MCD));
    // Suspend, woken by port match, then by comparator, then ended by a pin reset
    for (int s = 0; s < 3; s++)
    begin
      apb(1'b1, A_REF, 32'h8);
      apb(1'b1, A_CFG, (s == 1) ? 32'h14 : 32'h08);
      apb(1'b1, A_OSC, 32'h20);
      waitv(0, 1'b0, 40);
      check("susp", {28'h0, ztc_en_o, periph_clk_en_o, int_osc_en_o, port_match_en_o}, 32'h9);
      if (s == 2)
        pin_reset();
      k = n_wirq;
      kr = n_res;
      @(posedge clk_i);
      cmp_low_i <= (s < 2);
      repeat (10) @(negedge clk_i);
      check("cmp", 32'(cpu_clk_en_o), (s > 0) ? 32'h1 : 32'h0);
      @(posedge clk_i);
      port_match_i <= 1'b1;
      waitv(0, 1'b1, 10);
      repeat (2) @(negedge clk_i);
      check("wake", {16'(n_res - kr), 16'(n_wirq - k)}, (s < 2) ? 32'h00010001 : 32'h0);
      @(posedge clk_i);
      {cmp_low_i, port_match_i} <= 2'b00;
    end
    apb(1'b0, A_STA, 0); check("susp rst", rd_q, stat(pmc_pkg::PMC_RUN, pmc_pkg::PMC_CAUSE_PIN));
    test_done();
  end
endmodule
